// ==== core/omd_regs.svh ====
// Register offsets, field positions, reset values and limits of the on-chip memory decoder.
// Notes on behaviour
// RQ1: Direct 40H-7FH redirects to selected 64-byte bank.
// RQ2: Banks 0-3 internal RAM, 4-15 expanded RAM.
// RQ3: Bank map enable 1 redirects, 0 does not.
// RQ4: Expanded 768-byte RAM at external 0000h-02FFh.
// RQ5: Enabled data flash reads like external RAM.
// RQ6: Data flash changes only via programming, upper half.
// RQ7: Chip erase clears both flashes except locked region; here it clears them only while in-system programming is enabled.
// RQ8: Protected flash reads return all zero bytes.
// RQ9: Indirect reads: page register high, index low.
// RQ10: Indirect writes to data flash change nothing.
// RQ11: Page register selects pages, resets to zero.
// RQ12: Watchdog overflow sets bit 7 flag.
// RQ13: Bit 1 gates expanded RAM, reset disabled.
// RQ14: Data flash enable gates mapping, reset disabled.
// RQ15: Bit 0 inhibits free-running address-latch pulse.
// RQ16: Two enable bits route external accesses.
// RQ17: Window off means ordinary lower RAM.
// RQ18: Bank register write applies to next access.
`ifndef OMD_REGS_SVH
`define OMD_REGS_SVH

`define OMD_PAGE_OFS       8'h85
`define OMD_BANK_OFS       8'h86
`define OMD_SYSCTL_OFS     8'hbf

`define OMD_PAGE_RST       8'h00
`define OMD_BANK_SEL_RST   4'h1
`define OMD_BANK_EN_BIT    7
`define OMD_WDR_BIT        7
`define OMD_DATA_FLASH_ENABLE_BIT       3
`define OMD_IN_SYSTEM_PROGRAM_ENABLE_BIT       2
`define OMD_OME_BIT        1
`define OMD_LATCH_PULSE_INHIBIT_BIT       0

`define OMD_WIN_HI         2'b01
`define OMD_XRAM_LIMIT     16'h0300
`define OMD_XRAM_BASE      10'h100
`define OMD_RAM_DEPTH      1024

`endif

// ==== core/omd_pkg.sv ====
// Types shared by the on-chip memory decoder files.
package omd_pkg;

  // Internal data memory request from the core.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       direct;
    logic [7:0] addr;
    logic [7:0] wdata;
  } omd_ireq_t;

  // External data space request; ri marks the register-indirect form.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ri;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } omd_xreq_t;

  // Where an external data access lands, one-hot.
  typedef enum logic [3:0] {
    OMD_XT_NONE  = 4'b0001,
    OMD_XT_RAM   = 4'b0010,
    OMD_XT_FLASH = 4'b0100,
    OMD_XT_EXT   = 4'b1000
  } omd_xtgt_t;

endpackage

// ==== core/omd_ram.sv ====
// Single-port synchronous RAM holding the whole 1 KB of on-chip data memory.
`timescale 1ns/10ps
`default_nettype none
module omd_ram #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("omd_ram: DEPTH must equal 2**AW");
    end
  end

  // Array write; no reset so it maps onto a plain RAM macro.
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  // Read port; the output is cleared by reset so it is known from reset until the first read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (en && !we) begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// ==== core/omd_decoder.sv ====
// On-chip memory map decoder: bank window, external data routing and control registers.
`timescale 1ns/10ps
`default_nettype none
`include "omd_regs.svh"
module omd_decoder import omd_pkg::*; #(
  parameter int RAM_DEPTH = `OMD_RAM_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic             sfr_hit,
  output logic      [7:0]  sfr_rdata,
  input  wire omd_ireq_t   ireq,
  output logic      [7:0]  ireq_rdata,
  input  wire omd_xreq_t   xreq,
  output logic             xreq_busy,
  output logic      [7:0]  xreq_rdata,
  output logic             ext_rd,
  output logic             ext_wr,
  output logic      [15:0] ext_addr,
  output logic      [7:0]  ext_wdata,
  input  wire logic [7:0]  ext_rdata,
  output logic             dflash_rd,
  output logic      [15:0] dflash_addr,
  input  wire logic [7:0]  dflash_rdata,
  input  wire logic [7:0]  code_rdata_raw,
  output logic      [7:0]  code_rdata,
  input  wire logic        flash_protected,
  input  wire logic        flash_upper_address_bit,
  output logic             prog_addr_bit16,
  input  wire logic        chip_erase_req,
  input  wire logic [3:0]  lock_size,
  output logic             erase_program_flash,
  output logic             erase_data_flash,
  output logic             erase_keep_locked,
  input  wire logic        wdt_overflow,
  output logic             in_system_program_enable,
  output logic             latch_pulse_inhibit
);

  initial begin
    if (RAM_DEPTH != `OMD_RAM_DEPTH) begin
      $error("omd_decoder: the bank map needs exactly 1024 bytes of RAM");
    end
  end

  // Control registers.
  logic [7:0] page_high_byte_r;
  logic       bank_map_enable_r;
  logic [3:0] bank_select_field_r;
  logic       watchdog_reset_flag_r;
  logic       data_flash_enable_r;
  logic       isp_enable_r;
  logic       expanded_ram_enable_r;
  logic       latch_inhibit_r;

  // Register decode.
  wire page_sel   = (sfr_addr == `OMD_PAGE_OFS);
  wire bank_sel   = (sfr_addr == `OMD_BANK_OFS);
  wire sysctl_sel = (sfr_addr == `OMD_SYSCTL_OFS);
  wire page_we    = sfr_wr && page_sel;
  wire bank_we    = sfr_wr && bank_sel;
  wire sysctl_we  = sfr_wr && sysctl_sel;
  assign sfr_hit  = page_sel || bank_sel || sysctl_sel;

  // Read images; unused bits read as zero.
  wire [7:0] bank_img   = {bank_map_enable_r, 3'h0, bank_select_field_r};
  wire [7:0] sysctl_img = {watchdog_reset_flag_r, 3'h0, data_flash_enable_r,
                           isp_enable_r, expanded_ram_enable_r, latch_inhibit_r};
  wire [7:0] sfr_mux    = page_sel ? page_high_byte_r :
                          bank_sel ? bank_img :
                          sysctl_sel ? sysctl_img : 8'h00;

  // Page register, default page zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_high_byte_r <= `OMD_PAGE_RST; // RQ11
    end else if (page_we) begin
      page_high_byte_r <= sfr_wdata;
    end
  end

  // Bank control takes effect on the cycle after the write, ahead of any later access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_map_enable_r   <= 1'b0;
      bank_select_field_r <= `OMD_BANK_SEL_RST;
    end else if (bank_we) begin
      bank_map_enable_r   <= sfr_wdata[`OMD_BANK_EN_BIT]; // RQ18
      bank_select_field_r <= sfr_wdata[3:0];
    end
  end

  // The watchdog flag set wins over a software clear written in the same cycle.
  wire wdr_nxt = wdt_overflow ? 1'b1 :
                 sysctl_we ? sfr_wdata[`OMD_WDR_BIT] : watchdog_reset_flag_r;

  // System control bits, all disabled after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_reset_flag_r <= 1'b0;
      data_flash_enable_r   <= 1'b0; // RQ14
      isp_enable_r          <= 1'b0;
      expanded_ram_enable_r <= 1'b0; // RQ13
      latch_inhibit_r       <= 1'b0;
    end else begin
      watchdog_reset_flag_r <= wdr_nxt; // RQ12
      if (sysctl_we) begin
        data_flash_enable_r   <= sfr_wdata[`OMD_DATA_FLASH_ENABLE_BIT];
        isp_enable_r          <= sfr_wdata[`OMD_IN_SYSTEM_PROGRAM_ENABLE_BIT];
        expanded_ram_enable_r <= sfr_wdata[`OMD_OME_BIT];
        latch_inhibit_r       <= sfr_wdata[`OMD_LATCH_PULSE_INHIBIT_BIT];
      end
    end
  end

  // Register read data, one cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= sfr_mux;
    end
  end

  assign in_system_program_enable = isp_enable_r;
  assign latch_pulse_inhibit      = latch_inhibit_r; // RQ15

  // Bank window: bank number times 64 plus offset spans the whole 1 KB directly.
  wire       ireq_go  = ireq.rd || ireq.wr;
  wire       in_win   = ireq.direct && (ireq.addr[7:6] == `OMD_WIN_HI);
  wire       win_hit  = in_win && bank_map_enable_r; // RQ3
  wire [9:0] win_phys = {bank_select_field_r, ireq.addr[5:0]}; // RQ1 RQ2
  wire [9:0] lin_phys = {2'b00, ireq.addr}; // RQ17
  wire [9:0] i_phys   = win_hit ? win_phys : lin_phys;

  // External data address; the indirect form takes its high byte from the page register.
  wire [15:0] x_addr  = xreq.ri ? {page_high_byte_r, xreq.addr[7:0]} : xreq.addr; // RQ9
  wire        x_go    = xreq.rd || xreq.wr;
  wire        x_below = (x_addr < `OMD_XRAM_LIMIT);
  wire [9:0]  x_phys  = x_addr[9:0] + `OMD_XRAM_BASE; // RQ4

  // Routing by the two enable bits.
  omd_xtgt_t x_tgt;
  always_comb begin
    x_tgt = OMD_XT_NONE;
    if (x_go) begin
      unique case ({data_flash_enable_r, expanded_ram_enable_r}) // RQ16
        2'b00: x_tgt = OMD_XT_EXT;
        2'b01: x_tgt = x_below ? OMD_XT_RAM : OMD_XT_EXT; // RQ13
        2'b10: x_tgt = OMD_XT_FLASH; // RQ14
        2'b11: x_tgt = x_below ? OMD_XT_RAM : OMD_XT_FLASH;
      endcase
    end
  end

  // The core's internal access owns the single RAM port; an external RAM access waits.
  wire x_ram   = (x_tgt == OMD_XT_RAM);
  wire x_flash = (x_tgt == OMD_XT_FLASH);
  wire x_ext   = (x_tgt == OMD_XT_EXT);
  wire x_ram_go = x_ram && !ireq_go;
  assign xreq_busy = x_ram && ireq_go;

  wire       ram_en    = ireq_go || x_ram_go;
  wire       ram_we    = ireq_go ? ireq.wr : xreq.wr;
  wire [9:0] ram_addr  = ireq_go ? i_phys : x_phys;
  wire [7:0] ram_wdata = ireq_go ? ireq.wdata : xreq.wdata;
  logic [7:0] ram_q;

  omd_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (10)
  ) u_ram (
    .clk   (clk),
    .rst   (rst),
    .en    (ram_en),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_q)
  );

  // Data flash is read only here; writes of either form never reach it.
  assign dflash_rd   = x_flash && xreq.rd; // RQ5 RQ10 RQ6
  assign dflash_addr = x_addr;
  assign ext_rd      = x_ext && xreq.rd;
  assign ext_wr      = x_ext && xreq.wr;
  assign ext_addr    = x_addr;
  assign ext_wdata   = xreq.wdata;

  // Remember the source of an external read for the answer one cycle later.
  omd_xtgt_t xsrc_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xsrc_r <= OMD_XT_NONE;
    end else if (xreq.rd && !xreq_busy) begin
      xsrc_r <= x_tgt;
    end
  end

  // Protection hides every flash byte behind zero.
  wire [7:0] df_seen = flash_protected ? 8'h00 : dflash_rdata; // RQ8
  assign code_rdata  = flash_protected ? 8'h00 : code_rdata_raw; // RQ8
  assign ireq_rdata  = ram_q;

  always_comb begin
    xreq_rdata = 8'h00;
    unique case (xsrc_r)
      OMD_XT_NONE:  xreq_rdata = 8'h00;
      OMD_XT_RAM:   xreq_rdata = ram_q;
      OMD_XT_FLASH: xreq_rdata = df_seen;
      OMD_XT_EXT:   xreq_rdata = ext_rdata;
      default:      xreq_rdata = 8'h00;
    endcase
  end

  // Programming the upper half of the combined flash uses the upper address bit.
  assign prog_addr_bit16 = flash_upper_address_bit; // RQ6

  // Chip erase reaches both flashes only while in-system programming is enabled; a configured lock keeps the service region.
  assign erase_program_flash = chip_erase_req && isp_enable_r; // RQ7
  assign erase_data_flash    = chip_erase_req && isp_enable_r; // RQ7
  assign erase_keep_locked   = (lock_size != 4'h0);

  // Checks next to the logic they guard.
  a_win_remap: assert property (@(posedge clk) disable iff (rst) // RQ1
    (ireq_go && win_hit) |-> (ram_addr == {bank_select_field_r, ireq.addr[5:0]}))
    else $error("window access not sent to selected bank");
  a_win_off: assert property (@(posedge clk) disable iff (rst) // RQ17
    (ireq_go && !bank_map_enable_r) |-> (ram_addr == {2'b00, ireq.addr}))
    else $error("window off but address remapped");
  a_bank_xram: assert property (@(posedge clk) disable iff (rst) // RQ2
    (ireq_go && win_hit && bank_select_field_r >= 4'h4) |-> (ram_addr >= 10'h100))
    else $error("expanded bank mapped below expanded RAM");
  a_bank_next: assert property (@(posedge clk) disable iff (rst) // RQ18
    bank_we |=> (bank_select_field_r == $past(sfr_wdata[3:0])
                 && bank_map_enable_r == $past(sfr_wdata[7])))
    else $error("bank write not in effect next cycle");
  a_page_high: assert property (@(posedge clk) disable iff (rst) // RQ9
    (x_go && xreq.ri) |-> (ext_addr[15:8] == page_high_byte_r))
    else $error("indirect high byte not from page register");
  a_flash_nowr: assert property (@(posedge clk) disable iff (rst) // RQ10
    xreq.wr |-> !(dflash_rd || (x_flash && (ext_wr || ram_en && !ireq_go))))
    else $error("write leaked toward data flash");
  a_route_ext: assert property (@(posedge clk) disable iff (rst) // RQ16
    (x_go && !data_flash_enable_r && !(expanded_ram_enable_r && x_below))
      |-> (ext_rd || ext_wr))
    else $error("access not sent external");
  a_route_ram: assert property (@(posedge clk) disable iff (rst) // RQ4
    (xreq.rd && expanded_ram_enable_r && x_below && !ireq_go)
      |-> (ram_en && ram_addr == x_phys) ##1 (xreq_rdata == ram_q))
    else $error("expanded RAM read misrouted");
  a_protect_zero: assert property (@(posedge clk) disable iff (rst) // RQ8
    (flash_protected && xsrc_r == OMD_XT_FLASH) |-> (xreq_rdata == 8'h00 && code_rdata == 8'h00))
    else $error("protected flash byte visible");
  a_wdr_set: assert property (@(posedge clk) disable iff (rst) // RQ12
    wdt_overflow |=> watchdog_reset_flag_r ##1 (watchdog_reset_flag_r || $past(sysctl_we)))
    else $error("watchdog flag not set or not held");
  a_flash_read: assert property (@(posedge clk) disable iff (rst) // RQ5
    (xreq.rd && data_flash_enable_r && !(expanded_ram_enable_r && x_below))
      |-> dflash_rd && dflash_addr == x_addr ##1 (xreq_rdata == df_seen))
    else $error("data flash read not served");
  a_ale_inhibit: assert property (@(posedge clk) disable iff (rst) // RQ15
    (sysctl_we && sfr_wdata[0]) |=> latch_pulse_inhibit)
    else $error("latch pulse not inhibited");

  // Register state and routing gates; these catch a write landing in the wrong field.
  a_page_write: assert property (@(posedge clk) disable iff (rst) // RQ11
    page_we |=> (page_high_byte_r == $past(sfr_wdata)))
    else $error("page register write lost");
  a_sfr_read: assert property (@(posedge clk) disable iff (rst) // RQ11
    sfr_rd |=> (sfr_rdata == $past(sfr_mux)))
    else $error("register read data wrong");
  a_wdr_hold: assert property (@(posedge clk) disable iff (rst) // RQ12
    (!wdt_overflow && !sysctl_we) |=> (watchdog_reset_flag_r == $past(watchdog_reset_flag_r)))
    else $error("watchdog flag changed on its own");
  a_xram_off: assert property (@(posedge clk) disable iff (rst) // RQ13
    (x_go && !expanded_ram_enable_r) |-> !x_ram)
    else $error("expanded RAM reached while disabled");
  a_flash_off: assert property (@(posedge clk) disable iff (rst) // RQ14
    (x_go && !data_flash_enable_r) |-> !dflash_rd)
    else $error("data flash reached while disabled");
  a_xram_phys: assert property (@(posedge clk) disable iff (rst) // RQ4
    x_ram_go |-> (ram_addr >= 10'h100))
    else $error("expanded RAM access below its base");
  a_bank_low: assert property (@(posedge clk) disable iff (rst) // RQ2
    (ireq_go && win_hit && bank_select_field_r < 4'h4) |-> (ram_addr < 10'h100))
    else $error("low bank mapped outside lower RAM");
  a_busy_hold: assert property (@(posedge clk) disable iff (rst) // RQ4
    xreq_busy |=> (xsrc_r == $past(xsrc_r)))
    else $error("held-off read changed its source");
  a_code_zero: assert property (@(posedge clk) disable iff (rst) // RQ8
    flash_protected |-> (code_rdata == 8'h00))
    else $error("protected code byte visible");

endmodule
`default_nettype wire

// ==== verif/omd_mem_model.sv ====
// Behavioural data flash and external memory behind the decoder's data strobes.
`timescale 1ns/10ps
`default_nettype none
module omd_mem_model (
  input  wire logic        clk,
  input  wire logic        dflash_rd,
  input  wire logic [15:0] dflash_addr,
  output logic      [7:0]  dflash_rdata,
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_addr,
  output logic      [7:0]  ext_rdata
);
  // Data is valid the cycle after a strobe; idle cycles invert it so stale data never passes.
  always_ff @(posedge clk) begin
    dflash_rdata <= dflash_rd ? (dflash_addr[7:0] ^ dflash_addr[15:8] ^ 8'h5a) : ~dflash_rdata;
    ext_rdata    <= ext_rd ? (ext_addr[7:0] + 8'h33) : ~ext_rdata;
  end
endmodule
`default_nettype wire

// ==== verif/omd_decoder_tb_top.sv ====
// Self-checking testbench for the on-chip memory map decoder.
`timescale 1ns/10ps
`default_nettype none
module omd_decoder_tb_top import omd_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_rd = 1'b0;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  omd_ireq_t   ireq = '0;
  omd_xreq_t   xreq = '0;
  logic [7:0]  code_rdata_raw = 8'h00;
  logic        flash_protected = 1'b0;
  logic        flash_upper_address_bit = 1'b0;
  logic        chip_erase_req = 1'b0;
  logic [3:0]  lock_size = 4'h0;
  logic        wdt_overflow = 1'b0;
  logic        sfr_hit, xreq_busy, ext_rd, ext_wr, dflash_rd, prog_addr_bit16;
  logic        erase_program_flash, erase_data_flash, erase_keep_locked;
  logic        in_system_program_enable, latch_pulse_inhibit;
  logic [7:0]  sfr_rdata, ireq_rdata, xreq_rdata, ext_wdata, ext_rdata, dflash_rdata, code_rdata;
  logic [15:0] ext_addr, dflash_addr;
  int          fail_count = 0;
  int          checks_done = 0;

  omd_decoder u_omd_decoder (.clk, .rst, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_hit,
    .sfr_rdata, .ireq, .ireq_rdata, .xreq, .xreq_busy, .xreq_rdata, .ext_rd, .ext_wr,
    .ext_addr, .ext_wdata, .ext_rdata, .dflash_rd, .dflash_addr, .dflash_rdata,
    .code_rdata_raw, .code_rdata, .flash_protected, .flash_upper_address_bit,
    .prog_addr_bit16, .chip_erase_req, .lock_size, .erase_program_flash, .erase_data_flash,
    .erase_keep_locked, .wdt_overflow, .in_system_program_enable, .latch_pulse_inhibit);

  omd_mem_model u_omd_mem_model (.clk, .dflash_rd, .dflash_addr, .dflash_rdata, .ext_rd,
    .ext_addr, .ext_rdata);

  // Free-running clock at 125 MHz.
  always #4 clk = ~clk;

  // Compares one value and counts it; a mismatch is reported at once.
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Register write; the leading edge wait keeps a strobe from being set twice in one step.
  task automatic sfr_w(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic sfr_r(logic [7:0] a, output logic [7:0] q, output logic h);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    #1 h = sfr_hit;
    @(negedge clk);
    sfr_rd = 1'b0;
    q = sfr_rdata;
  endtask

  task automatic iacc(logic w, logic dir, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    ireq = '{!w, w, dir, a, d};
    @(negedge clk);
    ireq = '0;
    q = ireq_rdata;
  endtask

  // External data access; the core is idle, so the request is never held off.
  task automatic xacc(logic w, logic ri, logic [15:0] a, logic [7:0] d,
                      output logic [7:0] q, output logic [2:0] st);
    @(negedge clk);
    xreq = '{!w, w, ri, a, d};
    #1 st = {ext_rd, ext_wr, dflash_rd};
    @(negedge clk);
    xreq = '0;
    q = xreq_rdata;
  endtask

  task automatic t_regs();
    logic [7:0] ra[4] = '{8'h85, 8'h86, 8'hbf, 8'h87};
    logic [7:0] rv[4] = '{8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0] q;
    logic       h;
    for (int i = 0; i < 4; i++) begin
      sfr_r(ra[i], q, h);
      chk("reset_value", q, rv[i]);
      chk("sfr_hit", 8'(h), 8'(i < 3));
    end
    sfr_w(8'h86, 8'hff);
    sfr_r(8'h86, q, h);
    chk("bank_ctl_bits", q, 8'h8f);
  endtask

  // Each bank is written through the window in the cycle right after its select lands.
  task automatic t_window();
    logic [7:0] q;
    logic [2:0] st;
    for (int s = 0; s < 16; s++) begin
      @(negedge clk);
      sfr_addr = 8'h86;
      sfr_wdata = 8'h80 | 8'(s);
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      ireq = '{1'b0, 1'b1, 1'b1, 8'h41, 8'ha0 + 8'(s)};
      @(negedge clk);
      ireq = '0;
    end
    sfr_w(8'hbf, 8'h02);
    for (int s = 0; s < 16; s++) begin
      if (s < 4) iacc(1'b0, 1'b0, 8'(s * 64 + 1), 8'h00, q);
      else xacc(1'b0, 1'b0, 16'((s - 4) * 64 + 1), 8'h00, q, st);
      chk("window_bank", q, 8'ha0 + 8'(s));
    end
    sfr_w(8'h86, 8'h08);
    iacc(1'b1, 1'b1, 8'h41, 8'h77, q);
    iacc(1'b0, 1'b0, 8'h41, 8'h00, q);
    chk("window_off", q, 8'h77);
    xacc(1'b0, 1'b0, 16'h0101, 8'h00, q, st);
    chk("bank8_kept", q, 8'ha8);
  endtask

  // All four enable pairs, below and above the expanded RAM limit.
  task automatic t_route();
    logic [7:0]  q;
    logic [7:0]  e;
    logic [2:0]  st;
    logic [15:0] a;
    for (int m = 0; m < 8; m++) begin
      a = m[0] ? 16'h1234 : 16'h0101;
      sfr_w(8'hbf, {4'h0, m[2], 1'b0, m[1], 1'b0});
      xacc(1'b0, 1'b0, a, 8'h00, q, st);
      if (m[1] && !m[0]) e = 8'ha8;
      else if (m[2]) e = a[7:0] ^ a[15:8] ^ 8'h5a;
      else e = a[7:0] + 8'h33;
      chk("route_data", q, e);
    end
    sfr_w(8'h85, 8'h12);
    xacc(1'b0, 1'b1, 16'hff34, 8'h00, q, st);
    chk("paged_flash", q, 8'h7c);
    xacc(1'b1, 1'b1, 16'h0034, 8'h55, q, st);
    chk("paged_wr_strobes", 8'(st), 8'h00);
    xacc(1'b1, 1'b0, 16'h1234, 8'h55, q, st);
    chk("flash_wr_strobes", 8'(st), 8'h00);
    sfr_w(8'h85, 8'h01);
    xacc(1'b0, 1'b1, 16'h0001, 8'h00, q, st);
    chk("paged_ram", q, 8'ha8);
  endtask

  task automatic t_misc();
    logic [7:0] q;
    logic [2:0] st;
    logic       h;
    flash_protected = 1'b1;
    code_rdata_raw = 8'ha5;
    xacc(1'b0, 1'b0, 16'h1234, 8'h00, q, st);
    chk("prot_data", q, 8'h00);
    chk("prot_code", code_rdata, 8'h00);
    flash_protected = 1'b0;
    flash_upper_address_bit = 1'b1;
    #1;
    chk("open_code", code_rdata, 8'ha5);
    chk("addr_bit16", 8'(prog_addr_bit16), 8'h01);
    sfr_w(8'hbf, 8'h05);
    chk("isp_enable", 8'(in_system_program_enable), 8'h01);
    chip_erase_req = 1'b1;
    lock_size = 4'h3;
    #1;
    chk("erase", 8'({erase_program_flash, erase_data_flash, erase_keep_locked}), 8'h07);
    chip_erase_req = 1'b0;
    chk("latch_inhibit", 8'(latch_pulse_inhibit), 8'h01);
    @(negedge clk);
    wdt_overflow = 1'b1;
    @(negedge clk);
    wdt_overflow = 1'b0;
    sfr_r(8'hbf, q, h);
    chk("wdt_flag", q, 8'h85);
  endtask

  // Core access holds off an expanded RAM read; a paged write above the limit goes outside.
  task automatic t_paths();
    sfr_w(8'hbf, 8'h02);
    sfr_w(8'h85, 8'h12);
    @(negedge clk);
    ireq = '{1'b1, 1'b0, 1'b0, 8'h41, 8'h00};
    xreq = '{1'b1, 1'b0, 1'b0, 16'h0101, 8'h00};
    #1;
    chk("xreq_busy", 8'(xreq_busy), 8'h01);
    @(negedge clk);
    ireq = '0;
    chk("core_read", ireq_rdata, 8'h77);
    #1;
    chk("xreq_free", 8'(xreq_busy), 8'h00);
    @(negedge clk);
    chk("held_read", xreq_rdata, 8'ha8);
    xreq = '{1'b0, 1'b1, 1'b1, 16'h00c3, 8'h5c};
    #1;
    chk("ext_strobes", 8'({ext_rd, ext_wr, dflash_rd}), 8'h02);
    chk("ext_addr_hi", ext_addr[15:8], 8'h12);
    chk("ext_addr_lo", ext_addr[7:0], 8'hc3);
    chk("ext_wdata", ext_wdata, 8'h5c);
    chip_erase_req = 1'b1;
    lock_size = 4'h0;
    #1;
    chk("erase_gated", 8'({erase_program_flash, erase_data_flash}), 8'h00);
    chk("lock_clear", 8'(erase_keep_locked), 8'h00);
    @(negedge clk);
    xreq = '0;
    chip_erase_req = 1'b0;
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios in order.
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_window();
    t_route();
    t_misc();
    t_paths();
    end_of_test();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
